// ---- logic/dcc_pkg.sv ----
// Package of constants and types for the eight-channel DMA controller.
`default_nettype none
package dcc_pkg;
  localparam int NCH = 8;
  localparam logic [2:0] OFF_CTRL = 3'h0;
  localparam logic [2:0] OFF_REQ = 3'h1;
  localparam logic [2:0] OFF_STA = 3'h2;
  localparam logic [2:0] OFF_STB = 3'h3;
  localparam logic [2:0] OFF_PAD = 3'h4;
  localparam logic [2:0] OFF_CNT = 3'h5;
  localparam logic [11:0] OFF_COLL = 12'h100;
  localparam logic [11:0] OFF_ACT = 12'h104;
  localparam int B_ON = 15;
  localparam int B_BYTE = 14;
  localparam int B_DIR = 13;
  localparam int B_HALF = 12;
  localparam int B_NULL = 11;
  localparam int B_AM_HI = 5;
  localparam int B_AM_LO = 4;
  localparam int B_FORCE = 15;
  localparam logic [15:0] CTRL_MASK = 16'hF833;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [9:0] CNT_RST = 10'h000;
  localparam logic [3:0] LAST_RST = 4'hF;
  localparam logic [1:0] AM_POSTINC = 2'h0;
  localparam logic [1:0] MD_CONT = 2'h0;
  localparam logic [1:0] MD_ONE = 2'h1;
  localparam logic [1:0] MD_PP_CONT = 2'h2;
  localparam logic [1:0] MD_PP_ONE = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WT, ST_WR} dcc_state_type;
endpackage
`default_nettype wire

// ---- logic/dcc_top.sv ----
// Eight-channel DMA controller with APB registers and dedicated RAM and peripheral buses.
`default_nettype none
module dcc_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [127:0] dma_req,
  input wire logic [15:0] per_ind_addr,
  output logic [15:0] per_addr,
  output logic [15:0] per_wdata,
  output logic per_re,
  output logic per_we,
  output logic per_byte,
  input wire logic [15:0] per_rdata,
  input wire logic per_wr_collide,
  output logic [15:0] ram_addr,
  output logic [15:0] ram_wdata,
  output logic ram_re,
  output logic ram_we,
  output logic ram_byte,
  input wire logic [15:0] ram_rdata,
  input wire logic ram_wr_collide,
  output logic [7:0] ch_irq
);

  // Each channel owns six registers in a 32-byte window; two shared status words follow.
  // Software writes reach a register at the access edge of an APB transfer, while read data
  // is latched at the setup edge so that pready can stay high and no wait state is needed.
  // The transfer engine serves one channel at a time and spends four cycles on every move.
  // The engine is a four-state machine: idle, read, wait and write.
  // In the grant cycle it latches the channel's direction, size, null-write choice and both
  // addresses, so a register write in mid-transfer cannot tear the move that is in flight.
  // The cycle after the grant raises one read strobe on the source bus, the next captures
  // the returned data, and the third raises the write strobe on the destination bus.
  // The fourth cycle is idle again and may already grant the next pending channel.
  // The engine never touches the CPU bus; both far buses are dedicated to it.
  // Requests are remembered in one pending bit per channel until they are served.
  // Turning a channel off drops its pending request, so stale triggers never fire later.
  // A block ends after the programmed count plus one moves; the pointer then reloads.
  // Ping-pong modes alternate between the two start registers at every block end.
  // One-shot modes clear the on bit at the end of their last block.
  // The interrupt pulse lasts one cycle and is meant for a flag in the interrupt controller.
  // Collision flags are set by hardware and cleared by writing zero; a set wins a clear.
  // Peripheral indirect addressing takes the RAM address from the requester at the grant.
  // Register indirect addressing uses the channel pointer, with or without a post step.
  // Word moves step the pointer by two and byte moves by one, in RAM bytes.
  // The half-block interrupt replaces the full-block one for a channel that selects it.
  // Writes to a channel's peripheral address while it runs take effect from its next grant; start writes wait for its next reload.
  // A reserved addressing code behaves as peripheral indirect, since only its top bit counts.

  // Lowest set bit wins, so channel 0 has the highest priority.
  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = dcc_pkg::NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i[2:0];
      end
    end
    return r;
  endfunction

  // Sets the bit of one channel when hit is high.
  // It serves the write strobes, the grant vector and the status strobes alike.
  function automatic logic [7:0] ch_strobe(input logic hit, input logic [2:0] ch);
    logic [7:0] v;
    v = 8'h00;
    if (hit) begin
      v[ch] = 1'b1;
    end
    return v;
  endfunction

  logic [15:0] ctrl_q [dcc_pkg::NCH];
  logic [6:0] sel_q [dcc_pkg::NCH];
  logic [15:0] sta_q [dcc_pkg::NCH];
  logic [15:0] stb_q [dcc_pkg::NCH];
  logic [15:0] pad_q [dcc_pkg::NCH];
  logic [9:0] cnt_q [dcc_pkg::NCH];
  logic [15:0] ptr_q [dcc_pkg::NCH];
  logic [10:0] done_q [dcc_pkg::NCH];
  logic [7:0] pp_q;
  logic [7:0] pend_q;
  logic [7:0] ram_write_collision_q;
  logic [7:0] periph_write_collision_q;
  logic [3:0] last_q;
  logic [7:0] irq_q;
  dcc_pkg::dcc_state_type st_q;
  logic [2:0] cur_q;
  logic dir_q;
  logic byte_q;
  logic null_q;
  logic [15:0] ram_a_q;
  logic [15:0] per_a_q;
  logic [15:0] data_q;
  logic [15:0] per_wd_q;
  logic [31:0] rd_q;

  // APB decode: channel registers at 0x20 per channel, shared status at 0x100.
  // Offsets past the count register and outside both windows answer with an error.
  wire apb_setup = psel & ~penable;
  wire apb_acc = psel & penable;
  wire [2:0] a_ch = paddr[7:5];
  wire [2:0] a_reg = paddr[4:2];
  wire a_chan = (paddr[11:8] == 4'h0) & (a_reg <= dcc_pkg::OFF_CNT);
  wire a_coll = {paddr[11:2], 2'b00} == dcc_pkg::OFF_COLL;
  wire a_act = {paddr[11:2], 2'b00} == dcc_pkg::OFF_ACT;
  wire a_ok = a_chan | a_coll | a_act;
  wire wr_acc = apb_acc & pwrite & a_ok;
  wire wr_ch = apb_acc & pwrite & a_chan;

  // One write strobe per register kind, one bit per channel.
  wire [7:0] wr_ctrl_v = ch_strobe(wr_ch & (a_reg == dcc_pkg::OFF_CTRL), a_ch);
  wire [7:0] wr_req_v = ch_strobe(wr_ch & (a_reg == dcc_pkg::OFF_REQ), a_ch);
  wire [7:0] wr_sta_v = ch_strobe(wr_ch & (a_reg == dcc_pkg::OFF_STA), a_ch);
  wire [7:0] wr_stb_v = ch_strobe(wr_ch & (a_reg == dcc_pkg::OFF_STB), a_ch);
  wire [7:0] wr_pad_v = ch_strobe(wr_ch & (a_reg == dcc_pkg::OFF_PAD), a_ch);
  wire [7:0] wr_cnt_v = ch_strobe(wr_ch & (a_reg == dcc_pkg::OFF_CNT), a_ch);

  // Read values of the addressed registers, zero-extended to the bus width.
  // Both start offsets show the live pointer, so software can follow a block in flight.
  wire [31:0] rd_ctrl = {16'h0000, ctrl_q[a_ch]};
  wire [31:0] rd_req = {16'h0000, pend_q[a_ch], 8'h00, sel_q[a_ch]};
  wire [31:0] rd_ptr = {16'h0000, ptr_q[a_ch]};
  wire [31:0] rd_pad = {16'h0000, pad_q[a_ch]};
  wire [31:0] rd_cnt = {22'h000000, cnt_q[a_ch]};
  wire [31:0] rd_coll = {16'h0000, periph_write_collision_q, ram_write_collision_q};
  wire [31:0] rd_act = {20'h00000, last_q, pp_q};

  // Unmapped offsets read as zero.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (a_coll) begin
      rd_mux = rd_coll;
    end else if (a_act) begin
      rd_mux = rd_act;
    end else if (a_chan) begin
      case (a_reg)
        dcc_pkg::OFF_CTRL: rd_mux = rd_ctrl;
        dcc_pkg::OFF_REQ: rd_mux = rd_req;
        dcc_pkg::OFF_STA: rd_mux = rd_ptr;
        dcc_pkg::OFF_STB: rd_mux = rd_ptr;
        dcc_pkg::OFF_PAD: rd_mux = rd_pad;
        dcc_pkg::OFF_CNT: rd_mux = rd_cnt;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Read data is captured in the setup cycle, so no wait states are needed.
  // The captured word stands on prdata until the setup of the next read.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q <= 32'h0000_0000;
    end else if (apb_setup & ~pwrite) begin
      rd_q <= rd_mux;
    end
  end
  assign prdata = rd_q;
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~a_ok;

  // Request lines and arbitration.
  // A manual trigger and a selected request line both only set the pending bit.
  // A channel that is off sets nothing, whatever its request line does.
  // The lowest numbered ready channel wins each idle cycle.
  logic [7:0] on_v;
  logic [7:0] trig_v;
  logic [7:0] force_v;
  always_comb begin
    for (int c = 0; c < dcc_pkg::NCH; c++) begin
      on_v[c] = ctrl_q[c][dcc_pkg::B_ON];
      force_v[c] = wr_req_v[c] & pwdata[dcc_pkg::B_FORCE];
      trig_v[c] = on_v[c] & (dma_req[sel_q[c]] | force_v[c]);
    end
  end
  wire [7:0] ready_v = pend_q & on_v;
  wire grant = (st_q == dcc_pkg::ST_IDLE) & (|ready_v);
  wire [2:0] gch = first_set(ready_v);
  wire [7:0] gnt_v = ch_strobe(grant, gch);

  // A new request in the grant cycle stays pending.
  // A pending bit clears when its channel is granted or switched off.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 8'h00;
    end else begin
      pend_q <= trig_v | (pend_q & ~gnt_v & on_v);
    end
  end

  // Block completion of the channel being served.
  // The done counter counts moves within a block and is compared with count plus one.
  // With a count of zero the half point falls on the single move, so the pulse still comes.
  // Ping-pong toggles the selected start at each block end and clears it in other modes.
  wire fin = st_q == dcc_pkg::ST_WR;
  wire [15:0] cctl = ctrl_q[cur_q];
  wire [10:0] nd = done_q[cur_q] + 11'h001;
  wire [10:0] tot = {1'b0, cnt_q[cur_q]} + 11'h001;
  wire [10:0] hpt = (tot[10:1] == 10'h000) ? 11'h001 : {1'b0, tot[10:1]};
  wire blk_end = nd == tot;
  wire irq_hit = cctl[dcc_pkg::B_HALF] ? (nd == hpt) : blk_end;
  wire [1:0] cmode = cctl[1:0];
  wire pp_mode = cmode[1];
  wire cpp = pp_q[cur_q];
  wire nxt_pp = pp_mode & ~cpp;
  wire stop_blk = (cmode == dcc_pkg::MD_ONE) |
                  ((cmode == dcc_pkg::MD_PP_ONE) & cpp);
  wire [15:0] nxt_start = nxt_pp ? stb_q[cur_q] : sta_q[cur_q];
  wire postinc = cctl[dcc_pkg::B_AM_HI:dcc_pkg::B_AM_LO] == dcc_pkg::AM_POSTINC;
  wire [15:0] inc = byte_q ? 16'h0001 : 16'h0002;

  // Data moved from source to destination; byte moves keep the upper lane at zero.
  wire [15:0] src_data = dir_q ? ram_rdata : per_rdata;
  wire [15:0] moved = byte_q ? {8'h00, src_data[7:0]} : src_data;

  // Transfer engine: read, wait for data, write.
  // Addresses, direction, size and null choice are latched at the grant, so later register writes wait a move.
  // A move in flight always finishes, even if its channel is turned off meanwhile.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= dcc_pkg::ST_IDLE;
      cur_q <= 3'h0;
      dir_q <= 1'b0;
      byte_q <= 1'b0;
      null_q <= 1'b0;
      ram_a_q <= 16'h0000;
      per_a_q <= 16'h0000;
      data_q <= 16'h0000;
      per_wd_q <= 16'h0000;
    end else begin
      case (st_q)
        dcc_pkg::ST_IDLE: begin
          if (grant) begin
            st_q <= dcc_pkg::ST_RD;
            cur_q <= gch;
            dir_q <= ctrl_q[gch][dcc_pkg::B_DIR];
            byte_q <= ctrl_q[gch][dcc_pkg::B_BYTE];
            null_q <= ctrl_q[gch][dcc_pkg::B_NULL] & ~ctrl_q[gch][dcc_pkg::B_DIR];
            ram_a_q <= ctrl_q[gch][dcc_pkg::B_AM_HI] ? per_ind_addr : ptr_q[gch];
            per_a_q <= pad_q[gch];
          end
        end
        dcc_pkg::ST_RD: st_q <= dcc_pkg::ST_WT;
        dcc_pkg::ST_WT: begin
          st_q <= dcc_pkg::ST_WR;
          data_q <= moved;
          per_wd_q <= dir_q ? moved : 16'h0000;
        end
        dcc_pkg::ST_WR: st_q <= dcc_pkg::ST_IDLE;
        default: st_q <= dcc_pkg::ST_IDLE;
      endcase
    end
  end

  // Dedicated bus strobes; the CPU bus is never used.
  // Strobes are decoded from the state, so each lasts exactly one cycle.
  // Null writes put zero on the peripheral bus next to the RAM write.
  assign ram_addr = ram_a_q;
  assign per_addr = per_a_q;
  assign ram_wdata = data_q;
  assign per_wdata = per_wd_q;
  assign ram_byte = byte_q;
  assign per_byte = byte_q;
  assign ram_re = (st_q == dcc_pkg::ST_RD) & dir_q;
  assign per_re = (st_q == dcc_pkg::ST_RD) & ~dir_q;
  assign ram_we = fin & ~dir_q;
  assign per_we = fin & (dir_q | null_q);

  // Per-channel registers; a software write in the same cycle overrides hardware.
  // Enabling a channel reloads its pointer from the primary start and clears its progress.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int c = 0; c < dcc_pkg::NCH; c++) begin
        ctrl_q[c] <= dcc_pkg::REG_RST;
        sel_q[c] <= 7'h00;
        sta_q[c] <= dcc_pkg::REG_RST;
        stb_q[c] <= dcc_pkg::REG_RST;
        pad_q[c] <= dcc_pkg::REG_RST;
        cnt_q[c] <= dcc_pkg::CNT_RST;
        ptr_q[c] <= dcc_pkg::REG_RST;
        done_q[c] <= 11'h000;
      end
      pp_q <= 8'h00;
    end else begin
      for (int c = 0; c < dcc_pkg::NCH; c++) begin
        if (fin & (cur_q == c[2:0])) begin
          if (blk_end) begin
            done_q[c] <= 11'h000;
            ptr_q[c] <= nxt_start;
            pp_q[c] <= nxt_pp;
            if (stop_blk) begin
              ctrl_q[c][dcc_pkg::B_ON] <= 1'b0;
            end
          end else begin
            done_q[c] <= nd;
            if (postinc) begin
              ptr_q[c] <= ptr_q[c] + inc;
            end
          end
        end
        if (wr_ctrl_v[c]) begin
          ctrl_q[c] <= pwdata[15:0] & dcc_pkg::CTRL_MASK;
          if (pwdata[dcc_pkg::B_ON] & ~ctrl_q[c][dcc_pkg::B_ON]) begin
            ptr_q[c] <= sta_q[c];
            pp_q[c] <= 1'b0;
            done_q[c] <= 11'h000;
          end
        end
        if (wr_req_v[c]) begin
          sel_q[c] <= pwdata[6:0];
        end
        if (wr_sta_v[c]) begin
          sta_q[c] <= pwdata[15:0];
        end
        if (wr_stb_v[c]) begin
          stb_q[c] <= pwdata[15:0];
        end
        if (wr_pad_v[c]) begin
          pad_q[c] <= pwdata[15:0];
        end
        if (wr_cnt_v[c]) begin
          cnt_q[c] <= pwdata[9:0];
        end
      end
    end
  end

  // Shared status: collisions set over a clearing write, last channel, interrupts.
  wire wr_coll = wr_acc & a_coll;
  // A collision flag set by a write strobe stays set until software writes zero to it.
  wire [7:0] cur_v = ch_strobe(1'b1, cur_q);
  wire [7:0] xw_set = (ram_we & ram_wr_collide) ? cur_v : 8'h00;
  wire [7:0] pw_set = (per_we & per_wr_collide) ? cur_v : 8'h00;
  wire [7:0] xw_keep = wr_coll ? pwdata[7:0] : 8'hFF;
  wire [7:0] pw_keep = wr_coll ? pwdata[15:8] : 8'hFF;

  // The keep masks let a write of zero clear a flag while ones leave it alone.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ram_write_collision_q <= 8'h00;
      periph_write_collision_q <= 8'h00;
    end else begin
      ram_write_collision_q <= xw_set | (ram_write_collision_q & xw_keep);
      periph_write_collision_q <= pw_set | (periph_write_collision_q & pw_keep);
    end
  end

  // The last channel field keeps all ones until the first move completes.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      last_q <= dcc_pkg::LAST_RST;
    end else if (fin) begin
      last_q <= {1'b0, cur_q};
    end
  end

  // One pulse per block or half block, on the cycle after the write strobe.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 8'h00;
    end else begin
      irq_q <= (fin & irq_hit) ? cur_v : 8'h00;
    end
  end
  assign ch_irq = irq_q;

endmodule
`default_nettype wire

// ---- sim/dcc_monitor.sv ----
// Checker of strobe order, byte lanes and interrupt timing of the controller.
`default_nettype none
module dcc_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic per_re,
  input wire logic per_we,
  input wire logic per_byte,
  input wire logic [15:0] per_wdata,
  input wire logic ram_re,
  input wire logic ram_we,
  input wire logic ram_byte,
  input wire logic [15:0] ram_wdata,
  input wire logic [7:0] ch_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_p2r; per_re |-> !ram_re ##2 ram_we; endproperty
  a_p2r: assert property (p_p2r) else $error("no RAM write after read");
  property p_r2p; ram_re |-> ##2 (per_we && !ram_we); endproperty
  a_r2p: assert property (p_r2p) else $error("no peripheral write after read");
  property p_null; per_we && ram_we |-> per_wdata == 16'h0000; endproperty
  a_null: assert property (p_null) else $error("null write carries data");
  property p_pbyte; per_we && per_byte |-> per_wdata[15:8] == 8'h00; endproperty
  a_pbyte: assert property (p_pbyte) else $error("byte upper lane set");
  property p_rbyte; ram_we && ram_byte |-> ram_wdata[15:8] == 8'h00; endproperty
  a_rbyte: assert property (p_rbyte) else $error("byte upper lane set");
  property p_space; per_re || ram_re |=> !(per_re || ram_re) [*3]; endproperty
  a_space: assert property (p_space) else $error("transfers overlap");
  property p_irq; |ch_irq |-> $past(ram_we) || $past(per_we); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without write");
  property p_one; $onehot0(ch_irq); endproperty
  a_one: assert property (p_one) else $error("two interrupts at once");
endmodule
bind dcc_top dcc_monitor dcc_monitor_i (.*);
`default_nettype wire

// ---- sim/dcc_far_model.sv ----
// Behavioural model of the peripheral registers and the DMA RAM.
`default_nettype none
module dcc_far_model (
  input wire logic clk_sys,
  input wire logic [15:0] per_addr,
  input wire logic per_re,
  input wire logic per_we,
  input wire logic [15:0] ram_addr,
  input wire logic ram_re,
  input wire logic ram_we,
  output logic [15:0] per_rdata,
  output logic [15:0] ram_rdata,
  output logic per_wr_collide,
  output logic ram_wr_collide
);
  timeunit 1ns;
  timeprecision 1ps;
  initial per_rdata = 16'h1234;
  initial ram_rdata = 16'h4321;
  // Data is valid only the cycle after a read strobe; otherwise it toggles.
  always @(posedge clk_sys) begin
    per_rdata <= per_re ? per_addr ^ 16'h5A5A : ~per_rdata;
    ram_rdata <= ram_re ? ram_addr ^ 16'hC3C3 : ~ram_rdata;
  end
  assign per_wr_collide = per_we && per_addr == 16'hFFFE;
  assign ram_wr_collide = ram_we && ram_addr == 16'hFFFE;
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the eight-channel DMA controller.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pready, pslverr, per_re, per_we, per_byte, per_wr_collide;
  logic ram_re, ram_we, ram_byte, ram_wr_collide, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [127:0] dma_req = 128'h0;
  logic [15:0] per_ind_addr = 16'h0, per_addr, per_wdata, per_rdata;
  logic [15:0] ram_addr, ram_wdata, ram_rdata, sa, pa, ra, rb, pb;
  logic [7:0] ch_irq;
  logic [32:0] q[$];
  int errors = 0, total_checks = 0, cyc = 0, irqs[8];
  dcc_top dcc_top_i (.*);
  dcc_far_model dcc_far_model_i (.*);
  always #20 clk_sys = ~clk_sys;
  task check(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check({1'h0, rd}, {1'h0, e});
  endtask
  // Results are compared in the order the driver queued them.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      report_and_stop();
    end
    if (!sys_rst && ram_we) check({1'h0, ram_addr, ram_wdata}, q.size() ? q.pop_front() : '1);
    if (!sys_rst && per_we) check({1'h1, per_addr, per_wdata}, q.size() ? q.pop_front() : '0);
    for (int i = 0; i < 8; i++) if (ch_irq[i] === 1'h1) irqs[i]++;
  end
  initial begin
    rd = $urandom(32'h3400F100);
    sa = 16'($urandom()) & 16'hFFF0;
    pa = 16'($urandom()) & 16'hFFF0;
    ra = 16'($urandom()) & 16'hFFF0;
    rb = 16'($urandom()) & 16'hFFF0;
    pb = 16'($urandom()) & 16'hFFF0;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rdc(12'h104, 32'h00000F00);
    apb(1'h0, 12'h018, 32'h0);
    check({err, rd}, {1'h1, 32'h0});
    apb(1'h1, 12'h094, 32'hFFFFFFFF);
    rdc(12'h094, 32'h3FF);
    apb(1'h1, 12'h008, {16'h0, sa});
    apb(1'h1, 12'h010, {16'h0, pa});
    apb(1'h1, 12'h014, 32'h1);
    apb(1'h1, 12'h000, 32'h8801);
    for (int i = 0; i < 3; i++) begin
      if (i < 2) begin
        q.push_back({1'h0, sa + 16'(2 * i), pa ^ 16'h5A5A});
        q.push_back({1'h1, pa, 16'h0});
      end
      apb(1'h1, 12'h004, 32'h8000);
      repeat (6) @(posedge clk_sys);
      if (i == 0) rdc(12'h008, {16'h0, sa + 16'h2});
    end
    rdc(12'h008, {16'h0, sa});
    rdc(12'h000, 32'h0801);
    apb(1'h1, 12'h028, {16'h0, ra});
    apb(1'h1, 12'h030, {16'h0, pb});
    apb(1'h1, 12'h034, 32'h3);
    apb(1'h1, 12'h020, 32'hF000);
    for (int i = 0; i < 2; i++) begin
      q.push_back({1'h1, pb, 8'h0, ra[7:0] + 8'(i) ^ 8'hC3});
      apb(1'h1, 12'h024, 32'h8000);
      repeat (6) @(posedge clk_sys);
    end
    apb(1'h1, 12'h044, 32'h5);
    apb(1'h1, 12'h050, {16'h0, pa});
    apb(1'h1, 12'h040, 32'h8021);
    apb(1'h1, 12'h064, 32'h6);
    apb(1'h1, 12'h068, {16'h0, sa});
    apb(1'h1, 12'h070, {16'h0, pb});
    apb(1'h1, 12'h060, 32'h8011);
    q.push_back({1'h0, rb, pa ^ 16'h5A5A});
    q.push_back({1'h0, sa, pb ^ 16'h5A5A});
    per_ind_addr <= rb;
    dma_req[6:5] <= 2'h3;
    @(posedge clk_sys);
    dma_req <= 128'h0;
    repeat (12) @(posedge clk_sys);
    rdc(12'h104, 32'h00000300);
    apb(1'h1, 12'h0A8, {16'h0, ra});
    apb(1'h1, 12'h0AC, {16'h0, rb});
    apb(1'h1, 12'h0B0, {16'h0, pa});
    apb(1'h1, 12'h0A0, 32'h8003);
    for (int i = 0; i < 3; i++) begin
      if (i < 2) q.push_back({1'h0, (i == 1) ? rb : ra, pa ^ 16'h5A5A});
      apb(1'h1, 12'h0A4, 32'h8000);
      repeat (6) @(posedge clk_sys);
      if (i == 0) rdc(12'h104, 32'h00000520);
      if (i == 0) rdc(12'h0AC, {16'h0, rb});
    end
    rdc(12'h0A0, 32'h0003);
    apb(1'h1, 12'h0C8, 32'h0000FFFE);
    apb(1'h1, 12'h0D0, {16'h0, pa});
    apb(1'h1, 12'h0C0, 32'h8001);
    q.push_back({1'h0, 16'hFFFE, pa ^ 16'h5A5A});
    apb(1'h1, 12'h0C4, 32'h8000);
    repeat (6) @(posedge clk_sys);
    rdc(12'h100, 32'h00000040);
    apb(1'h1, 12'h100, 32'h0);
    rdc(12'h100, 32'h0);
    rdc(12'h104, 32'h00000600);
    for (int i = 0; i < 8; i++) check(33'(irqs[i]), 33'((i < 4 || i == 6) ? 1 : ((i == 5) ? 2 : 0)));
    check(33'(q.size()), 33'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
